// >>> logic/perf_monitor.sv
// Performance monitor counters with APB register access.
// Assumes event inputs are one-cycle pulses, qualified by the line clock enable.
//
// Function
// [RULE1] A write to any count address copies all counts to holding registers, then clears them.
// [RULE2] Latch and clear align with event timing so no event is lost or doubled.
// [RULE3] The host writes exactly one count address per polling cycle.
// [RULE4] Holding registers update within 3.5 line clock periods after the write.
// [RULE5] The host waits the settling time before reading the holding registers.
// [RULE6] Holding contents are undefined after reset until the first latch.
// [RULE7] The transfer flag sets on a transfer and clears on a status read.
// [RULE8] The overrun flag sets when a transfer hits an unread transfer flag; read clears it.
// [RULE9] The host writes zero to the reserved status bit.
// [RULE10] A 12-bit violation counter splits into low byte and upper nibble.
// [RULE11] A 9-bit bit error counter splits into low byte and bit 0 of the next.
// [RULE12] Bit error events are chosen by framing mode, up to seven per frame.
// [RULE13] A 5-bit framing error counter reads in bits 4 to 0.
// [RULE14] A 3-bit counter counts out-of-frame or alignment-change events by a select bit.
// [RULE15] Every counter saturates instead of wrapping.
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
module perf_monitor (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic line_clk_en_i,
   input wire logic bpv_i,
   input wire logic [2:0] bit_err_num_i,
   input wire logic frame_bit_err_i,
   input wire logic out_of_frame_event_i,
   input wire logic alignment_change_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire [7:0] reg_idx = paddr[9:2];
   wire access = psel && penable;
   wire wr = access && pwrite;
   wire rd = access && !pwrite;
   wire hit_count = (reg_idx >= perf_monitor_pkg::IDX_VIOL_LO) &&
                    (reg_idx <= perf_monitor_pkg::IDX_ALIGN);
   wire hit_status = reg_idx == perf_monitor_pkg::IDX_STATUS;
   wire hit_ctrl = reg_idx == perf_monitor_pkg::IDX_CONTROL;
   wire mapped = hit_count || hit_status || hit_ctrl;
   wire aligned = paddr[1:0] == 2'b00;
   wire latch_wr = wr && hit_count && aligned; // [RULE1]
   wire status_rd = rd && hit_status && aligned; // [RULE7] [RULE8]

   // ------------------------------------------------------------
   // Software control
   // ------------------------------------------------------------
   logic rsvd_bit;
   logic alignment_change_select;
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rsvd_bit <= 1'b0;
         alignment_change_select <= 1'b0;
      end
      else if (wr && hit_status && aligned)
         rsvd_bit <= pwdata[perf_monitor_pkg::BIT_RSVD];
      else if (wr && hit_ctrl && aligned)
         alignment_change_select <= pwdata[perf_monitor_pkg::BIT_ALIGN_SEL];
   end

   // ------------------------------------------------------------
   // Latch sequencer
   // ------------------------------------------------------------
   // Latch waits for the next line clock enable so copy and clear land between events
   perf_monitor_pkg::latch_state_t state;
   perf_monitor_pkg::latch_state_t next_state;
   always_comb
   begin
      next_state = state;
      case (state)
         perf_monitor_pkg::ST_IDLE:
            if (latch_wr)
               next_state = perf_monitor_pkg::ST_WAIT;
         perf_monitor_pkg::ST_WAIT:
            if (line_clk_en_i)
               next_state = perf_monitor_pkg::ST_COPY; // [RULE2] [RULE4]
         perf_monitor_pkg::ST_COPY:
            next_state = perf_monitor_pkg::ST_IDLE;
         default:
            next_state = perf_monitor_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         state <= perf_monitor_pkg::ST_IDLE;
      else
         state <= next_state;
   end
   wire do_copy = state == perf_monitor_pkg::ST_COPY;

   // ------------------------------------------------------------
   // Live counters
   // ------------------------------------------------------------
   wire perf_monitor_pkg::event_t ev;
   assign ev.viol = line_clk_en_i && bpv_i;
   assign ev.biterr = line_clk_en_i && (bit_err_num_i != 3'h0);
   assign ev.framerr = line_clk_en_i && frame_bit_err_i;
   assign ev.frame_loss = line_clk_en_i && out_of_frame_event_i;
   assign ev.realign = line_clk_en_i && alignment_change_i;
   wire align_inc = alignment_change_select ? ev.realign : ev.frame_loss; // [RULE14]

   wire perf_monitor_pkg::counts_t live;
   perf_monitor_pkg::counts_t hold;
   sat_counter #(.W(perf_monitor_pkg::VIOL_W)) u_viol (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .inc_i(ev.viol), // [RULE10]
      .clr_i(do_copy),
      .count_o(live.viol)
   );
   sat_counter #(.W(perf_monitor_pkg::FRAMERR_W)) u_framerr (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .inc_i(ev.framerr), // [RULE13]
      .clr_i(do_copy),
      .count_o(live.framerr)
   );
   sat_counter #(.W(perf_monitor_pkg::ALIGN_W)) u_align (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .inc_i(align_inc),
      .clr_i(do_copy),
      .count_o(live.align)
   );

   // Bit error counter adds up to seven errors at once, saturating
   logic [8:0] biterr_cnt;
   wire [9:0] biterr_sum = {1'b0, biterr_cnt} + {7'h00, bit_err_num_i}; // [RULE12]
   wire [8:0] biterr_step = biterr_sum[9] ? 9'h1FF : biterr_sum[8:0]; // [RULE15]
   wire [8:0] biterr_base = ev.biterr ? biterr_step : biterr_cnt;
   wire [8:0] next_biterr = do_copy ? (ev.biterr ? {6'h00, bit_err_num_i} : 9'h000) :
                            biterr_base; // [RULE11]
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         biterr_cnt <= 9'h000;
      else
         biterr_cnt <= next_biterr;
   end
   assign live.biterr = biterr_cnt;

   // ------------------------------------------------------------
   // Holding registers and status
   // ------------------------------------------------------------
   // Holding has no reset; contents mean nothing before the first latch
   always_ff @(posedge clk_sys_i)
   begin
      if (do_copy)
         hold <= live; // [RULE1] [RULE6]
   end

   logic transfer_done_flag;
   logic holding_overrun_flag;
   // Set wins over a read clear; a read clears only what its data showed,
   // so a transfer landing between setup and access is not lost
   wire shown_done = status_rd && prdata[perf_monitor_pkg::BIT_DONE];
   wire shown_overrun = status_rd && prdata[perf_monitor_pkg::BIT_OVERRUN];
   wire next_done = do_copy || (transfer_done_flag && !shown_done); // [RULE7]
   wire next_overrun = (do_copy && transfer_done_flag) ||
                       (holding_overrun_flag && !shown_overrun); // [RULE8]
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         transfer_done_flag <= 1'b0;
         holding_overrun_flag <= 1'b0;
      end
      else
      begin
         transfer_done_flag <= next_done;
         holding_overrun_flag <= next_overrun;
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (reg_idx)
         perf_monitor_pkg::IDX_STATUS:
         begin
            rd_mux[perf_monitor_pkg::BIT_OVERRUN] = holding_overrun_flag;
            rd_mux[perf_monitor_pkg::BIT_DONE] = transfer_done_flag;
            rd_mux[perf_monitor_pkg::BIT_RSVD] = rsvd_bit;
         end
         perf_monitor_pkg::IDX_VIOL_LO: rd_mux[7:0] = hold.viol[7:0]; // [RULE10]
         perf_monitor_pkg::IDX_VIOL_HI: rd_mux[3:0] = hold.viol[11:8]; // [RULE10]
         perf_monitor_pkg::IDX_BITERR_LO: rd_mux[7:0] = hold.biterr[7:0]; // [RULE11]
         perf_monitor_pkg::IDX_BITERR_HI: rd_mux[0] = hold.biterr[8]; // [RULE11]
         perf_monitor_pkg::IDX_FRAMERR: rd_mux[4:0] = hold.framerr; // [RULE13]
         perf_monitor_pkg::IDX_ALIGN: rd_mux[2:0] = hold.align; // [RULE14]
         perf_monitor_pkg::IDX_CONTROL:
            rd_mux[perf_monitor_pkg::BIT_ALIGN_SEL] = alignment_change_select;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= rd_mux;
   end
   // Zero wait states; a write during a pending latch still counts as one request
   assign pready = 1'b1;
   assign pslverr = access && !(mapped && aligned);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Sequencer
   a_latch_timing: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE4]
      state == perf_monitor_pkg::ST_WAIT && line_clk_en_i |=> do_copy)
      else $error("latch copy not on next line enable");
   a_latch_accept: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE1]
      latch_wr && state == perf_monitor_pkg::ST_IDLE |=> state == perf_monitor_pkg::ST_WAIT)
      else $error("latch write not taken");
   a_wait_holds: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE2]
      state == perf_monitor_pkg::ST_WAIT && !line_clk_en_i |=> state == perf_monitor_pkg::ST_WAIT)
      else $error("latch copied between line enables");
   a_idle_quiet: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE1]
      state == perf_monitor_pkg::ST_IDLE && !latch_wr |=> state == perf_monitor_pkg::ST_IDLE)
      else $error("latch started without a write");
   a_unaligned_no_latch: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE1]
      wr && hit_count && !aligned && state == perf_monitor_pkg::ST_IDLE |=>
      state == perf_monitor_pkg::ST_IDLE)
      else $error("refused write started a latch");
   a_sequencer_bound: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE2]
      state == perf_monitor_pkg::ST_COPY |=> state == perf_monitor_pkg::ST_IDLE)
      else $error("latch sequencer stuck");

   // Copy and flags
   a_copy_clears: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE1]
      do_copy && !line_clk_en_i |=> live.viol == 12'h000 && live.biterr == 9'h000 &&
      live.framerr == 5'h00 && live.align == 3'h0)
      else $error("counters not cleared by latch");
   a_hold_loaded: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE2]
      do_copy |=> hold == $past(live))
      else $error("holding values differ from live counts");
   a_done_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE7]
      do_copy |=> transfer_done_flag)
      else $error("transfer flag not set");
   a_done_keeps: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE7]
      transfer_done_flag && !shown_done |=> transfer_done_flag)
      else $error("transfer flag lost without a read");
   a_done_clear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE7]
      shown_done && !do_copy |=> !transfer_done_flag)
      else $error("transfer flag not cleared by read");
   a_overrun_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE8]
      do_copy && transfer_done_flag |=> holding_overrun_flag)
      else $error("overrun not flagged");
   a_overrun_clear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE8]
      shown_overrun && !do_copy |=> !holding_overrun_flag)
      else $error("overrun not cleared by read");
   a_overrun_cause: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE8]
      $rose(holding_overrun_flag) |-> $past(do_copy) && $past(transfer_done_flag))
      else $error("overrun set without cause");

   // Counters
   a_viol_count: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE10]
      !do_copy && ev.viol && live.viol != 12'hFFF |=>
      live.viol == $past(live.viol) + 12'h001)
      else $error("violation not counted");
   a_viol_saturate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE15]
      live.viol == 12'hFFF && !do_copy |=> live.viol == 12'hFFF)
      else $error("violation counter wrapped");
   a_framerr_count: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE13]
      !do_copy && ev.framerr && live.framerr != 5'h1F |=>
      live.framerr == $past(live.framerr) + 5'h01)
      else $error("framing error not counted");
   a_framerr_saturate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE15]
      live.framerr == 5'h1F && !do_copy |=> live.framerr == 5'h1F)
      else $error("framing error counter wrapped");
   a_biterr_step: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE12]
      !do_copy && line_clk_en_i && biterr_cnt < 9'h1F0 |=>
      biterr_cnt == $past(biterr_cnt) + $past(bit_err_num_i))
      else $error("bit error count step wrong");
   a_biterr_saturate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE15]
      biterr_cnt == 9'h1FF && !do_copy |=> biterr_cnt == 9'h1FF)
      else $error("bit error counter wrapped");
   a_align_count: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE14]
      !do_copy && align_inc && live.align != 3'h7 |=>
      live.align == $past(live.align) + 3'h1)
      else $error("selected alignment event not counted");
   a_align_select: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE14]
      !do_copy && ev.realign && !ev.frame_loss && !alignment_change_select
      |=> live.align == $past(live.align))
      else $error("alignment change counted while out-of-frame selected");
endmodule

// >>> logic/perf_monitor_pkg.sv
// Package: register map, field layout and timing for the performance monitor.
// Assumes a 10 MHz system clock and APB with 32-bit data.
package perf_monitor_pkg;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_STATUS = 8'h49;
   localparam logic [7:0] IDX_VIOL_LO = 8'h4A;
   localparam logic [7:0] IDX_VIOL_HI = 8'h4B;
   localparam logic [7:0] IDX_BITERR_LO = 8'h4C;
   localparam logic [7:0] IDX_BITERR_HI = 8'h4D;
   localparam logic [7:0] IDX_FRAMERR = 8'h4E;
   localparam logic [7:0] IDX_ALIGN = 8'h4F;
   localparam logic [7:0] IDX_CONTROL = 8'h60;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_OVERRUN = 0;
   localparam int BIT_DONE = 1;
   localparam int BIT_RSVD = 2;
   localparam int BIT_ALIGN_SEL = 0;
   localparam int VIOL_W = 12;
   localparam int BITERR_W = 9;
   localparam int FRAMERR_W = 5;
   localparam int ALIGN_W = 3;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int SETTLE_NS = 2300;
   localparam int SETTLE_CYC = SETTLE_NS / CLK_PERIOD_NS;
   localparam int LATCH_MAX_CYC = 4;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic viol;
      logic biterr;
      logic framerr;
      logic frame_loss;
      logic realign;
   } event_t;
   typedef struct packed {
      logic [11:0] viol;
      logic [8:0] biterr;
      logic [4:0] framerr;
      logic [2:0] align;
   } counts_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_COPY = 2'b11
   } latch_state_t;
endpackage

// >>> logic/sat_counter.sv
// Saturating event counter with synchronous clear.
// Assumes inc and clr are single-cycle qualified strobes.
`timescale 1ns/10ps
module sat_counter #(
   parameter int W = 8
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic inc_i,
   input wire logic clr_i,
   output logic [W-1:0] count_o
);
   wire at_max = &count_o;
   // Clear with simultaneous event restarts at one, so nothing is lost
   wire [W-1:0] next_count = clr_i ? {{(W-1){1'b0}}, inc_i} :
                             (inc_i && !at_max) ? count_o + 1'b1 : count_o; // [RULE15]
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         count_o <= '0;
      else
         count_o <= next_count;
   end
endmodule

// >>> bench/perf_monitor_test.sv
// Testbench for the performance monitor counters, driven over APB.
// Assumes an APB slave that may add wait states; line ticks come every 8 clocks.
`timescale 1ns/10ps
module perf_monitor_test;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic line_clk_en_i = 1'b0;
   logic bpv_i = 1'b0;
   logic [2:0] bit_err_num_i = 3'h0;
   logic frame_bit_err_i = 1'b0;
   logic out_of_frame_event_i = 1'b0;
   logic alignment_change_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] rd;
   logic err;
   int fails = 0;
   int samples_checked = 0;

   perf_monitor dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .line_clk_en_i(line_clk_en_i),
      .bpv_i(bpv_i), .bit_err_num_i(bit_err_num_i), .frame_bit_err_i(frame_bit_err_i),
      .out_of_frame_event_i(out_of_frame_event_i), .alignment_change_i(alignment_change_i),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial
   begin
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task results;
      if (fails == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %0t got %h want %h", $time, seen, exp);
      end
   endtask

   // Holds the request until pready is seen high; no wait count assumed
   task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      @(posedge clk_sys_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      @(posedge clk_sys_i);
      while (pready !== 1'b1)
         @(posedge clk_sys_i);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task reg_wr(input logic [7:0] idx, input logic [31:0] wd);
      apb(1'b1, {2'b00, idx, 2'b00}, wd);
   endtask

   task reg_rd(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, {2'b00, idx, 2'b00}, 32'h0);
      check(rd, exp);
   endtask

   // One line tick carrying the given events
   task tick(input logic b, input logic [2:0] n, input logic f, input logic o, input logic c);
      @(posedge clk_sys_i);
      line_clk_en_i <= 1'b1;
      bpv_i <= b;
      bit_err_num_i <= n;
      frame_bit_err_i <= f;
      out_of_frame_event_i <= o;
      alignment_change_i <= c;
      @(posedge clk_sys_i);
      line_clk_en_i <= 1'b0;
      bpv_i <= 1'b0;
      bit_err_num_i <= 3'h0;
      frame_bit_err_i <= 1'b0;
      out_of_frame_event_i <= 1'b0;
      alignment_change_i <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
   endtask

   // Three line ticks: 24 clocks, past the settling time, under 3.5 periods
   task latch(input logic [7:0] idx);
      reg_wr(idx, 32'h0);
      repeat (3) tick(1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
   endtask

   task read_counts(input logic [11:0] l, input logic [8:0] b, input logic [4:0] f,
      input logic [2:0] o);
      reg_rd(perf_monitor_pkg::IDX_VIOL_LO, {24'h0, l[7:0]});
      reg_rd(perf_monitor_pkg::IDX_VIOL_HI, {28'h0, l[11:8]});
      reg_rd(perf_monitor_pkg::IDX_BITERR_LO, {24'h0, b[7:0]});
      reg_rd(perf_monitor_pkg::IDX_BITERR_HI, {31'h0, b[8]});
      reg_rd(perf_monitor_pkg::IDX_FRAMERR, {27'h0, f});
      reg_rd(perf_monitor_pkg::IDX_ALIGN, {29'h0, o});
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task test_reset;
      reg_rd(perf_monitor_pkg::IDX_STATUS, 32'h0);
      reg_rd(perf_monitor_pkg::IDX_CONTROL, 32'h0);
      reg_wr(perf_monitor_pkg::IDX_STATUS, 32'h0);
   endtask

   // Alignment pulses must not count while out-of-frame is selected
   task test_counts;
      for (int i = 0; i < 300; i++)
         tick(1'b1, (i < 90) ? 3'h3 : 3'h0, i < 20, i < 2, i < 5);
      latch(perf_monitor_pkg::IDX_VIOL_HI);
      read_counts(12'd300, 9'd270, 5'd20, 3'd2);
      reg_rd(perf_monitor_pkg::IDX_STATUS, 32'h2);
      reg_rd(perf_monitor_pkg::IDX_STATUS, 32'h0);
   endtask

   // Second latch with the transfer flag unread gives overrun and empty counts
   task test_saturate;
      for (int i = 0; i < 4100; i++)
         tick(1'b1, 3'h7, 1'b1, 1'b1, 1'b0);
      latch(perf_monitor_pkg::IDX_FRAMERR);
      read_counts(12'hFFF, 9'h1FF, 5'h1F, 3'h7);
      latch(perf_monitor_pkg::IDX_BITERR_LO);
      read_counts(12'h000, 9'h000, 5'h00, 3'h0);
      reg_rd(perf_monitor_pkg::IDX_STATUS, 32'h3);
      reg_rd(perf_monitor_pkg::IDX_STATUS, 32'h0);
   endtask

   task test_select;
      reg_wr(perf_monitor_pkg::IDX_CONTROL, 32'h1);
      reg_rd(perf_monitor_pkg::IDX_CONTROL, 32'h1);
      for (int i = 0; i < 6; i++)
         tick(1'b0, 3'h0, 1'b0, i < 1, i < 4);
      latch(perf_monitor_pkg::IDX_ALIGN);
      read_counts(12'h000, 9'h000, 5'h00, 3'h4);
      reg_rd(perf_monitor_pkg::IDX_STATUS, 32'h2);
      reg_wr(perf_monitor_pkg::IDX_CONTROL, 32'h0);
   endtask

   // Events on the tick that completes a latch land in the old period, later ones in the new
   task test_boundary;
      tick(1'b1, 3'h1, 1'b1, 1'b1, 1'b0);
      reg_wr(perf_monitor_pkg::IDX_ALIGN, 32'h0);
      tick(1'b1, 3'h5, 1'b1, 1'b0, 1'b0);
      repeat (2) tick(1'b1, 3'h2, 1'b0, 1'b1, 1'b0);
      read_counts(12'd2, 9'd6, 5'd2, 3'd1);
      latch(perf_monitor_pkg::IDX_VIOL_LO);
      read_counts(12'd2, 9'd4, 5'd0, 3'd2);
      reg_rd(perf_monitor_pkg::IDX_STATUS, 32'h3);
   endtask

   // Unmapped and unaligned accesses are refused and never latch
   task test_unmapped;
      apb(1'b0, 12'h1C0, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      apb(1'b1, 12'h12B, 32'h0);
      check({31'h0, err}, 32'h1);
      repeat (3) tick(1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
      reg_rd(perf_monitor_pkg::IDX_STATUS, 32'h0);
   endtask

   initial
   begin
      repeat (20) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      test_reset();
      test_counts();
      test_saturate();
      test_select();
      test_boundary();
      test_unmapped();
      results();
   end

   // Tests need about 35600 clocks
   initial
   begin
      repeat (60000) @(posedge clk_sys_i);
      fails++;
      results();
   end
endmodule
